// ===== dv/afc_checker.sv
`timescale 1ns/1ps
module afc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic drdy_n,
  input wire logic reset_n_pin
);
  // ------------------------------------------------------------
  // Frame tracking
  // ------------------------------------------------------------
  logic [3:0] nrise_q, nrise_d, age_q, age_d;
  logic [2:0] cs_hi_q, cs_hi_d, pin_lo_q, pin_lo_d;
  logic       sck_q, sck_d, rd_q, rd_d;

  // Saturating counts, so long idle spans never wrap
  always_comb begin
    sck_d    = sck;
    nrise_d  = nrise_q;
    rd_d     = rd_q;
    age_d    = (age_q != 4'hF) ? age_q + 4'h1 : age_q;
    cs_hi_d  = (cs_hi_q != 3'h7) ? cs_hi_q + 3'h1 : cs_hi_q;
    pin_lo_d = (pin_lo_q != 3'h7) ? pin_lo_q + 3'h1 : pin_lo_q;
    if (!sck && sck_q) begin
      age_d = 4'h0;
    end
    if (sck && !sck_q && nrise_q != 4'hF) begin
      nrise_d = nrise_q + 4'h1;
      if (nrise_q == 4'h7) begin
        rd_d = sdi;
      end
    end
    if (cs_n) begin
      nrise_d = 4'h0;
      rd_d    = 1'b0;
    end else begin
      cs_hi_d = 3'h0;
    end
    if (reset_n_pin) begin
      pin_lo_d = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {nrise_q, age_q, cs_hi_q, pin_lo_q, sck_q, rd_q} <= '0;
    end else begin
      {nrise_q, age_q, cs_hi_q, pin_lo_q, sck_q, rd_q} <=
        {nrise_d, age_d, cs_hi_d, pin_lo_d, sck_d, rd_d};
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_sdo_cs_idle;
    cs_hi_q >= 3'h4 |-> !sdo_oe;
  endproperty
  a_sdo_cs_idle: assert property (p_sdo_cs_idle)
    else $error("output driven while deselected");
  property p_sdo_pin_rst;
    pin_lo_q >= 3'h4 |-> !sdo_oe;
  endproperty
  a_sdo_pin_rst: assert property (p_sdo_pin_rst)
    else $error("output driven during pin reset");
  property p_drdy_rst;
    pin_lo_q == 3'h7 |-> drdy_n;
  endproperty
  a_drdy_rst: assert property (p_drdy_rst)
    else $error("ready pulse during pin reset");
  property p_cmd_hiz;
    !cs_n && nrise_q != 4'h0 && nrise_q < 4'h8 |-> !sdo_oe;
  endproperty
  a_cmd_hiz: assert property (p_cmd_hiz)
    else $error("output driven in command byte");
  property p_wr_hiz;
    !cs_n && nrise_q >= 4'h8 && !rd_q |-> !sdo_oe;
  endproperty
  a_wr_hiz: assert property (p_wr_hiz)
    else $error("output driven in write");
  property p_rd_drive;
    !cs_n && reset_n_pin && rd_q && nrise_q == 4'hA |-> sdo_oe;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("read data not driven");
  property p_shift_fall;
    sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> age_q <= 4'h5;
  endproperty
  a_shift_fall: assert property (p_shift_fall)
    else $error("output changed away from falling edge");
  property p_drdy_width;
    $fell(drdy_n) |-> ##[1:64] drdy_n;
  endproperty
  a_drdy_width: assert property (p_drdy_width)
    else $error("ready pulse too long");
  property p_drdy_gap;
    $rose(drdy_n) |-> drdy_n [*8];
  endproperty
  a_drdy_gap: assert property (p_drdy_gap)
    else $error("ready pulses too close");
  property p_drdy_rel;
    $rose(reset_n_pin) |-> drdy_n [*8];
  endproperty
  a_drdy_rel: assert property (p_drdy_rel)
    else $error("ready pulse right after release");
endmodule

// ===== dv/test_afe_clock_reset_serial_pins.sv
`timescale 1ns/1ps
module test_afe_clock_reset_serial_pins;
  import afc_pkg::*;
  logic       clk = 1'b0, resetn = 1'b0, start = 1'b0, cpol = 1'b0;
  logic       xtal_en = 1'b1, osc = 1'b0, ext_sel = 1'b0;
  logic       dev_reset_n = 1'b0, cmd_valid_q, wr_valid_q, data_rate_q;
  logic       busy_q, done_q, drdy_seen_q;
  logic [1:0] pre = 2'h0;
  logic [2:0] osr = 3'h3;
  logic [7:0] rd_data = 8'h00, cmd = 8'h00, wdata = 8'h00;
  logic [7:0] cmd_q, wr_data_q, rdata_q, seed = 8'h5F;
  logic [9:0] exp_q[$];
  int         n_mismatch = 0, check_count = 0;

  afc_if bus ();
  afc_device i_afc_device (.clk(clk), .resetn(resetn),
    .crystal_clock_en(xtal_en), .oscillator_input_pin(osc),
    .external_clock_select(ext_sel), .prescale_sel(pre),
    .oversampling_select(osr), .rd_data(rd_data), .cmd_q(cmd_q),
    .cmd_valid_q(cmd_valid_q), .wr_data_q(wr_data_q),
    .wr_valid_q(wr_valid_q), .data_rate_q(data_rate_q), .pins(bus));
  afc_host i_afc_host (.clk(clk), .resetn(resetn), .start(start),
    .cmd(cmd), .wdata(wdata), .cpol(cpol), .dev_reset_n(dev_reset_n),
    .busy_q(busy_q), .rdata_q(rdata_q), .done_q(done_q),
    .drdy_seen_q(drdy_seen_q), .pins(bus));
  afc_checker i_afc_checker (.clk(clk), .resetn(resetn),
    .cs_n(bus.cs_n), .sck(bus.sck), .sdi(bus.sdi), .sdo_o(bus.sdo_o),
    .sdo_oe(bus.sdo_oe), .drdy_n(bus.drdy_n),
    .reset_n_pin(bus.reset_n_pin));

  // Pin clock rises every 4 cycles, off the sampling edge
  always #5 clk = ~clk;
  initial begin
    #3;
    forever #20 osc = ~osc;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // Oldest note first; kind 3 marks a result of no interest
  task automatic note(input logic [1:0] k, input logic [7:0] v);
    logic [9:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : {~k, v};
    if (e[9:8] == 2'h3 && k == 2'h2) e = {k, v};
    check(e === {k, v}, "serial result");
  endtask

  always @(posedge clk) begin
    if (cmd_valid_q === 1'b1) note(2'h0, cmd_q);
    if (wr_valid_q === 1'b1) note(2'h1, wr_data_q);
    if (done_q === 1'b1) note(2'h2, rdata_q);
  end

  task automatic xfer(input logic [7:0] c, w, r, input logic en);
    int n;
    @(posedge clk);
    #1;
    cmd = c;
    wdata = w;
    rd_data = r;
    start = 1'b1;
    if (en) exp_q.push_back({2'h0, c});
    if (en && !c[AFC_RW_BIT]) exp_q.push_back({2'h1, w});
    exp_q.push_back({(en && c[AFC_RW_BIT]) ? 2'h2 : 2'h3, r});
    @(posedge clk);
    #1;
    start = 1'b0;
    check(busy_q === 1'b1, "busy not raised");
    n = 0;
    while (done_q !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n < 400, "transfer hung");
    check(busy_q === 1'b0, "busy not cleared");
    repeat (2) @(posedge clk);
  endtask

  task automatic wait_lvl(input logic v, input int lim, output int n);
    n = 0;
    while (bus.drdy_n !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  // Settings are applied under pin reset, then timed from release
  task automatic rate(input logic [1:0] p, input logic [2:0] o,
                      input logic ext, input int tick);
    int per, n, lo;
    @(posedge clk);
    #1;
    dev_reset_n = 1'b0;
    pre = p;
    osr = o;
    ext_sel = ext;
    repeat (12) @(posedge clk);
    #1;
    dev_reset_n = 1'b1;
    per = tick * 4 * (32 << o) * (1 << p);
    wait_lvl(1'b0, per + 64, n);
    check(n + 16 > per && n < per + 16, "first ready");
    check(data_rate_q === 1'b1, "no rate strobe");
    wait_lvl(1'b1, 200, lo);
    check(lo == 2 * tick * (1 << p), "ready width");
    wait_lvl(1'b0, per + 64, n);
    check(lo + n == per, "ready period");
    check(drdy_seen_q === 1'b0, "ready seen early");
    @(posedge clk);
    #1;
    check(drdy_seen_q === 1'b1, "ready not seen");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #900_000;
    n_mismatch++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    wrap_up;
  end

  initial begin
    logic [7:0] c, w;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      #1;
      cpol = i[1];
      dev_reset_n = (i != 5);
      seed = lfsr(seed);
      c = {seed[7:1], i[0]};
      seed = lfsr(seed);
      w = seed;
      seed = lfsr(seed);
      xfer(c, w, seed, dev_reset_n);
    end
    check(exp_q.size() == 0, "missing serial result");
    $display("serial test done");
    for (int o = 0; o < 8; o++) rate(2'h0, o[2:0], 1'b0, 1);
    for (int p = 1; p < 4; p++) rate(p[1:0], 3'h0, 1'b0, 1);
    rate(2'h0, 3'h0, 1'b1, 4);
    $display("rate test done");
    wrap_up;
  end
endmodule

// ===== inc/afc_if.sv
`timescale 1ns/1ps
interface afc_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_o;
  logic sdo_oe;
  logic drdy_n;
  logic reset_n_pin;
  modport device (input cs_n, input sck, input sdi, input reset_n_pin,
                  output sdo_o, output sdo_oe, output drdy_n);
  modport host (output cs_n, output sck, output sdi, output reset_n_pin,
                input sdo_o, input sdo_oe, input drdy_n);
endinterface

// ===== inc/afc_pkg.sv
package afc_pkg;
  // Prescale field codes
  localparam logic [1:0] AFC_PRE_DIV1 = 2'h0;
  localparam logic [1:0] AFC_PRE_DIV2 = 2'h1;
  localparam logic [1:0] AFC_PRE_DIV4 = 2'h2;
  localparam logic [1:0] AFC_PRE_DIV8 = 2'h3;
  localparam logic [1:0] AFC_PRE_RST  = AFC_PRE_DIV1;
  // Oversampling field
  localparam int         AFC_OSR_W    = 3;
  localparam logic [2:0] AFC_OSR_RST  = 3'h3;
  localparam int         AFC_OSR_MINLOG = 5;
  localparam int         AFC_CNT_W    = 12;
  // Digital clock = analog clock / 4
  localparam int         AFC_DM_DIV   = 4;
  localparam logic [1:0] AFC_DM_LAST  = 2'h3;
  localparam logic [1:0] AFC_DM_HALF  = 2'h1;
  // Serial framing
  localparam int         AFC_CMD_W    = 8;
  localparam int         AFC_BIT_W    = 4;
  localparam logic [3:0] AFC_CMD_LAST = 4'h7;
  localparam int         AFC_RW_BIT   = 0;
  localparam int         AFC_DATA_W   = 8;
  // Host serial clock divider (100 MHz / (2*4) = 12.5 MHz)
  localparam int         AFC_SCK_HALF = 4;
  typedef enum logic [1:0] {
    AFC_IDLE = 2'b00,
    AFC_CMD  = 2'b01,
    AFC_RD   = 2'b11,
    AFC_WR   = 2'b10
  } afc_state_e;
endpackage

// ===== rtl/afc_clk_div.sv
`timescale 1ns/1ps
module afc_clk_div
  import afc_pkg::*;
#(
  parameter int CNT_W = AFC_CNT_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             run,
  // Settings
  input  wire logic [1:0]       prescale_sel,
  input  wire logic [2:0]       oversampling_select,
  // Enables
  output logic                  analog_master_clock,
  output logic                  digital_master_clock,
  output logic                  dm_half,
  output logic                  data_rate_clock
);
  import afc_pkg::*;

  logic [2:0]       pre_q, pre_d;
  logic [1:0]       dm_q, dm_d;
  logic [CNT_W-1:0] osr_q, osr_d;

  function automatic logic [2:0] pre_last(input logic [1:0] s);
    pre_last = 3'((4'h1 << s) - 4'h1);
  endfunction

  function automatic logic [CNT_W-1:0] osr_last(input logic [2:0] s);
    osr_last = CNT_W'((32'h1 << (AFC_OSR_MINLOG + 32'(s))) - 32'h1);
  endfunction

  always_comb begin
    analog_master_clock  = run && (pre_q >= pre_last(prescale_sel));
    digital_master_clock = analog_master_clock && (dm_q == AFC_DM_LAST);
    dm_half              = analog_master_clock && (dm_q == AFC_DM_HALF);
    data_rate_clock      = digital_master_clock &&
                           (osr_q >= osr_last(oversampling_select));
    pre_d = pre_q;
    dm_d  = dm_q;
    osr_d = osr_q;
    if (run) begin
      pre_d = analog_master_clock ? 3'h0 : pre_q + 3'h1;
      if (analog_master_clock) begin
        dm_d = dm_q + 2'h1;
      end
      if (digital_master_clock) begin
        osr_d = data_rate_clock ? '0 : osr_q + 1'b1;
      end
    end
  end

  // Counters restart at zero on reset release
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 3'h0;
      dm_q  <= 2'h0;
      osr_q <= '0;
    end else begin
      pre_q <= pre_d;
      dm_q  <= dm_d;
      osr_q <= osr_d;
    end
  end
endmodule

// ===== rtl/afc_device.sv
// What this block does
// - External select picks pin clock over crystal
// - Analog clock is master over 1,2,4,8
// - Digital clock is analog clock over four
// - Data-rate clock is digital over OSR
// - OSR codes map 32 through 4096
// - Host keeps analog clock within range
// - Reset defaults settings, refuses serial traffic
// - No internal clock distributed during reset
// - Fully operational right after reset release
// - Select low frames transaction; high ignores
// - Sample rising, shift falling; modes 0,0/1,1
// - Serial clock asynchronous to master clock
// - Transaction opens with eight-bit command
// - Output driven only during read data
// - Input ignored after read command
// - Ready pulses low half digital period
// - Oversampling defaults to ratio 256
`timescale 1ns/1ps
module afc_device
  import afc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Master clock sources
  input  wire logic                  crystal_clock_en,
  input  wire logic                  oscillator_input_pin,
  // Settings
  input  wire logic                  external_clock_select,
  input  wire logic [1:0]            prescale_sel,
  input  wire logic [2:0]            oversampling_select,
  // Read data and decoded command
  input  wire logic [AFC_DATA_W-1:0] rd_data,
  output logic [AFC_CMD_W-1:0]       cmd_q,
  output logic                       cmd_valid_q,
  output logic [AFC_DATA_W-1:0]      wr_data_q,
  output logic                       wr_valid_q,
  output logic                       data_rate_q,
  // Pins
  afc_if.device                      pins
);
  import afc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] s_cs, s_sck, s_sdi, s_rst, s_osc;
  logic       sck_prev_q, cs_prev_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_cs       <= 2'h3;
      s_sck      <= 2'h0;
      s_sdi      <= 2'h0;
      s_rst      <= 2'h0;
      s_osc      <= 2'h0;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      s_cs       <= {s_cs[0], pins.cs_n};
      s_sck      <= {s_sck[0], pins.sck};
      s_sdi      <= {s_sdi[0], pins.sdi};
      s_rst      <= {s_rst[0], pins.reset_n_pin};
      s_osc      <= {s_osc[0], oscillator_input_pin};
      sck_prev_q <= s_sck[1];
      cs_prev_q  <= s_cs[1];
    end
  end

  logic cs_n, rst_ok, sck_rise, sck_fall, cs_fall;
  assign cs_n     = s_cs[1];
  assign rst_ok   = s_rst[1];
  assign sck_rise = s_sck[1] && !sck_prev_q;
  assign sck_fall = !s_sck[1] && sck_prev_q;
  assign cs_fall  = !cs_n && cs_prev_q;

  // ---------------------------------------------------------------
  // Clock generation
  // ---------------------------------------------------------------
  logic osc_prev_q, mclk_tick, run;
  logic am, dm, dm_half, dr;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= s_osc[1];
    end
  end

  // Crystal off when external clock is chosen
  assign mclk_tick = external_clock_select ? (s_osc[1] && !osc_prev_q)
                                           : crystal_clock_en;
  // Master reset gates distribution
  assign run = rst_ok && mclk_tick;

  afc_clk_div #(
    .CNT_W (AFC_CNT_W)
  ) u_div (
    .clk                  (clk),
    .resetn               (resetn && rst_ok),
    .run                  (run),
    .prescale_sel         (rst_ok ? prescale_sel : AFC_PRE_RST),
    .oversampling_select  (rst_ok ? oversampling_select
                                  : AFC_OSR_RST),
    .analog_master_clock  (am),
    .digital_master_clock (dm),
    .dm_half              (dm_half),
    .data_rate_clock      (dr)
  );

  // ---------------------------------------------------------------
  // Data ready pulse
  // ---------------------------------------------------------------
  logic drdy_n_q, drdy_n_d, dr_q, dr_d;

  always_comb begin
    drdy_n_d = drdy_n_q;
    dr_d     = dr;
    if (!rst_ok) begin
      drdy_n_d = 1'b1;
    end else if (dr) begin
      drdy_n_d = 1'b0;
    end else if (dm_half) begin
      drdy_n_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drdy_n_q <= 1'b1;
      dr_q     <= 1'b0;
    end else begin
      drdy_n_q <= drdy_n_d;
      dr_q     <= dr_d;
    end
  end
  assign pins.drdy_n = drdy_n_q;
  assign data_rate_q = dr_q;

  // ---------------------------------------------------------------
  // Serial framing
  // ---------------------------------------------------------------
  afc_state_e             st_q, st_d;
  logic [AFC_BIT_W-1:0]   cnt_q, cnt_d;
  logic [AFC_CMD_W-1:0]   sh_q, sh_d, cmd_d;
  logic [AFC_DATA_W-1:0]  tx_q, tx_d, wrd_d;
  logic                   cv_d, wv_d, sdo_q, sdo_d, oe_q, oe_d;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    sh_d  = sh_q;
    tx_d  = tx_q;
    cmd_d = cmd_q;
    wrd_d = wr_data_q;
    cv_d  = 1'b0;
    wv_d  = 1'b0;
    sdo_d = sdo_q;
    oe_d  = oe_q;
    // Refuse all traffic in reset or while deselected
    if (!rst_ok || cs_n) begin
      st_d = AFC_IDLE;
      oe_d = 1'b0;
    end else if (cs_fall) begin
      st_d  = AFC_CMD;
      cnt_d = '0;
    end else begin
      case (st_q)
        AFC_CMD: begin
          if (sck_rise) begin
            sh_d  = {sh_q[AFC_CMD_W-2:0], s_sdi[1]};
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == AFC_CMD_LAST) begin
              cmd_d = sh_d;
              cv_d  = 1'b1;
              cnt_d = '0;
              st_d  = sh_d[AFC_RW_BIT] ? AFC_RD : AFC_WR;
              tx_d  = rd_data;
            end
          end
        end
        AFC_RD: begin
          // Input ignored here; drive only on falling edges
          if (sck_fall) begin
            oe_d  = 1'b1;
            sdo_d = tx_q[AFC_DATA_W-1];
            tx_d  = {tx_q[AFC_DATA_W-2:0], tx_q[AFC_DATA_W-1]};
          end
        end
        AFC_WR: begin
          if (sck_rise) begin
            wrd_d = {wr_data_q[AFC_DATA_W-2:0], s_sdi[1]};
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == AFC_CMD_LAST) begin
              wv_d  = 1'b1;
              cnt_d = '0;
            end
          end
        end
        default: begin
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q        <= AFC_IDLE;
      cnt_q       <= '0;
      sh_q        <= '0;
      tx_q        <= '0;
      cmd_q       <= '0;
      wr_data_q   <= '0;
      cmd_valid_q <= 1'b0;
      wr_valid_q  <= 1'b0;
      sdo_q       <= 1'b0;
      oe_q        <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      sh_q        <= sh_d;
      tx_q        <= tx_d;
      cmd_q       <= cmd_d;
      wr_data_q   <= wrd_d;
      cmd_valid_q <= cv_d;
      wr_valid_q  <= wv_d;
      sdo_q       <= sdo_d;
      oe_q        <= oe_d;
    end
  end
  // Dividers run from the first tick after release
  assign pins.sdo_o  = sdo_q;
  assign pins.sdo_oe = oe_q;
endmodule

// ===== rtl/afc_host.sv
`timescale 1ns/1ps
module afc_host
  import afc_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // User request
  input  wire logic                  start,
  input  wire logic [AFC_CMD_W-1:0]  cmd,
  input  wire logic [AFC_DATA_W-1:0] wdata,
  input  wire logic                  cpol,
  input  wire logic                  dev_reset_n,
  output logic                       busy_q,
  output logic [AFC_DATA_W-1:0]      rdata_q,
  output logic                       done_q,
  output logic                       drdy_seen_q,
  // Pins
  afc_if.host                        pins
);
  import afc_pkg::*;

  afc_state_e           st_q, st_d;
  logic [3:0]           div_q, div_d;
  logic [4:0]           nb_q, nb_d;
  logic [AFC_CMD_W-1:0] sh_q, sh_d;
  logic [AFC_DATA_W-1:0] rd_d;
  logic cs_q, cs_d, sck_q, sck_d, pol_q, pol_d, busy_d, done_d;

  always_comb begin
    st_d = st_q; div_d = div_q; nb_d = nb_q; sh_d = sh_q;
    rd_d = rdata_q; cs_d = cs_q; sck_d = sck_q; pol_d = pol_q;
    busy_d = busy_q; done_d = 1'b0;
    case (st_q)
      AFC_IDLE: begin
        // Mode changes only while deselected
        // Clock loads cpol on the same edge that select falls
        pol_d = cpol;
        sck_d = cpol;
        if (start) begin
          st_d = AFC_CMD; cs_d = 1'b0; sh_d = cmd;
          nb_d = '0; div_d = '0; busy_d = 1'b1;
        end
      end
      default: begin
        div_d = div_q + 4'h1;
        if (div_q == 4'(AFC_SCK_HALF - 1)) begin
          div_d = '0;
          sck_d = !sck_q;
          if (sck_q) begin // falling: next bit out; rising samples
            if (nb_q == 5'(2 * AFC_CMD_W)) begin
              st_d = AFC_IDLE; cs_d = 1'b1; busy_d = 1'b0; done_d = 1'b1;
              sck_d = pol_q;
            end
          end else begin
            nb_d = nb_q + 5'h1;
            if (nb_q == 5'(AFC_CMD_W - 1)) begin
              st_d = cmd[AFC_RW_BIT] ? AFC_RD : AFC_WR;
            end
            if (st_q == AFC_RD) begin
              rd_d = {rdata_q[AFC_DATA_W-2:0], pins.sdo_o && pins.sdo_oe};
            end
          end
          // Mode 1,1 opens on a fall that must not shift
          if (sck_q && st_q != AFC_RD && nb_q != '0) begin
            sh_d = (nb_q == 5'(AFC_CMD_W)) ? wdata
                                            : {sh_q[AFC_CMD_W-2:0], 1'b0};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= AFC_IDLE; div_q <= '0; nb_q <= '0; sh_q <= '0;
      rdata_q <= '0; cs_q <= 1'b1; sck_q <= 1'b0; pol_q <= 1'b0;
      busy_q <= 1'b0; done_q <= 1'b0;
      drdy_seen_q <= 1'b0;
    end else begin
      st_q <= st_d; div_q <= div_d; nb_q <= nb_d; sh_q <= sh_d;
      rdata_q <= rd_d; cs_q <= cs_d; sck_q <= sck_d; pol_q <= pol_d;
      busy_q <= busy_d; done_q <= done_d;
      // Same clock as the device, so no synchroniser
      drdy_seen_q <= !pins.drdy_n;
    end
  end
  assign pins.cs_n        = cs_q;
  assign pins.sck         = sck_q;
  assign pins.sdi         = sh_q[AFC_CMD_W-1];
  assign pins.reset_n_pin = dev_reset_n;
endmodule
